/* efst_pkg.sv */
// Constants, types and helper functions for the encoder framing and homing core.
// Assumes one clock domain; all sample and byte strobes arrive from pins.

package efst_pkg;

    // ------------------------------------------------------------
    // Frame and word geometry
    // ------------------------------------------------------------
    localparam int unsigned FRAME_SAMPLES = 160;
    localparam int unsigned SAMP_BITS     = 13;
    localparam int unsigned WORD_BITS     = 16;
    localparam int unsigned LAW_BITS      = 8;
    localparam int unsigned COD_WORDS     = 76;
    localparam int unsigned PARAM_BITS    = 6;
    localparam int unsigned FIFO_DEPTH    = 8;
    localparam int unsigned FIFO_WIDTH    = WORD_BITS + 1;
    localparam int unsigned SCNT_W        = 8;
    localparam int unsigned BCNT_W        = 4;
    localparam int unsigned CCNT_W        = 7;
    localparam int unsigned LIN_RATE_KBPS = 104;

    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [WORD_BITS-1:0]  HOME_WORD  = 16'h0008;
    localparam logic [WORD_BITS-1:0]  SIG_SEED   = 16'h5a3c; // Arbitrary seed
    localparam logic [WORD_BITS-1:0]  SIG_POLY   = 16'h1021;
    localparam logic [PARAM_BITS-1:0] DHF_BASE   = 6'h15;    // Arbitrary pattern base
    localparam logic [LAW_BITS-1:0]   ALAW_XOR   = 8'h55;
    localparam logic [SAMP_BITS:0]    MU_BIAS    = 14'h0084;
    localparam logic [SCNT_W-1:0]     LAST_SAMP  = 8'h9f;
    localparam logic [BCNT_W-1:0]     LAST_BIT   = 4'hc;
    localparam logic [CCNT_W-1:0]     LAST_WORD  = 7'h4b;

    typedef enum logic [0:0] {
        EFST_IDLE = 1'b0,
        EFST_EMIT = 1'b1
    } efst_state_t;

    // Signature step: shifts one 13-bit sample into a 16-bit CRC
    function automatic logic [WORD_BITS-1:0] efst_sig_step(input logic [WORD_BITS-1:0] sig,
                                                          input logic [SAMP_BITS-1:0] smp);
        logic [WORD_BITS-1:0] s;
        s = sig;
        for (int i = SAMP_BITS - 1; i >= 0; i--) begin
            s = (s[WORD_BITS-1] ^ smp[i]) ? ({s[WORD_BITS-2:0], 1'b0} ^ SIG_POLY) : {s[WORD_BITS-2:0], 1'b0};
        end
        return s;
    endfunction

    // Compressed byte to 13-bit two's complement linear
    function automatic logic [SAMP_BITS-1:0] efst_law_expand(input logic [LAW_BITS-1:0] b, input logic alaw);
        logic [LAW_BITS-1:0] v;
        logic [SAMP_BITS:0]  mag;
        logic                neg;
        v   = alaw ? (b ^ ALAW_XOR) : ~b;
        neg = alaw ? ~v[7] : v[7];
        if (alaw) begin
            mag = (v[6:4] == 3'h0) ? {9'h000, v[3:0], 1'b1} : ({8'h00, 1'b1, v[3:0], 1'b1} << (v[6:4] - 3'h1));
        end else begin
            mag = ((({8'h00, v[3:0], 1'b1} + (MU_BIAS >> 2)) << v[6:4]) - (MU_BIAS >> 2)) >> 1;
        end
        return neg ? SAMP_BITS'(-mag) : SAMP_BITS'(mag);
    endfunction

endpackage

/* efst_fifo_if.sv */
// Valid/ready word channel between the core and its output FIFO.
// Assumes both ends share one clock.
`timescale 1ns/100ps

interface efst_fifo_if #(parameter int unsigned WIDTH = 17);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* efst_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides.
// Assumes DEPTH is a power of two and one clock domain.
`timescale 1ns/100ps

module efst_fifo #(
    parameter int unsigned WIDTH = 17,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic   i_clock,
    input  wire logic   i_rst_b,
    input  wire logic   i_ce,
    efst_fifo_if.snk    wr,
    efst_fifo_if.src    rd
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0]    wptr_q, wptr_d;
    logic [AW-1:0]    rptr_q, rptr_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        wr.ready = (cnt_q != (AW+1)'(DEPTH));
        rd.valid = (cnt_q != '0);
        rd.data  = mem_q[rptr_q];
        push     = wr.valid & wr.ready;
        pop      = rd.valid & rd.ready;
        mem_d    = mem_q;
        wptr_d   = wptr_q;
        rptr_d   = rptr_q;
        if (push) begin
            mem_d[wptr_q] = wr.data;
            wptr_d        = wptr_q + AW'(1);
        end
        if (pop) begin
            rptr_d = rptr_q + AW'(1);
        end
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q  <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (i_ce) begin
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            cnt_q  <= cnt_d;
            mem_q  <= mem_d;
        end
    end

endmodule // efst_fifo

/* efst_core.sv */
// Encoder front end: sample framing, homing detection and coded frame output.
// Assumes serial linear bits or compressed bytes arrive from pins with strobes.
`timescale 1ns/100ps

module efst_core
    import efst_pkg::*;
(
    input  wire logic                 i_clock,
    input  wire logic                 i_rst_b,
    input  wire logic                 i_ce,
    input  wire logic                 i_law_mode,
    input  wire logic                 i_law_alaw,
    input  wire logic                 i_lin_bit,
    input  wire logic                 i_lin_strobe,
    input  wire logic [LAW_BITS-1:0]  i_law_byte,
    input  wire logic                 i_law_strobe,
    input  wire logic                 i_cod_ready,
    output logic      [WORD_BITS-1:0] o_cod_word,
    output logic                      o_cod_first,
    output logic                      o_cod_valid,
    output logic                      o_home_seen,
    output logic                      o_overrun
);
    localparam int unsigned PIN_W = LAW_BITS + 5;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [PIN_W-1:0]     sync1_q, sync1_d;
    logic [PIN_W-1:0]     sync2_q, sync2_d;
    logic                 lstb_q, lstb_d;
    logic                 bstb_q, bstb_d;
    logic [SAMP_BITS-2:0] shreg_q, shreg_d;
    logic [BCNT_W-1:0]    bcnt_q, bcnt_d;
    logic [SCNT_W-1:0]    scnt_q, scnt_d;
    logic                 all_home_q, all_home_d;
    logic                 prev_home_q, prev_home_d;
    logic [WORD_BITS-1:0] sig_q, sig_d;
    logic [WORD_BITS-1:0] cod_sig_q, cod_sig_d;
    logic                 dhf_sel_q, dhf_sel_d;
    logic [CCNT_W-1:0]    cidx_q, cidx_d;
    efst_state_t          st_q, st_d;
    logic                 home_seen_q, home_seen_d;
    logic                 overrun_q, overrun_d;

    logic                 p_mode, p_alaw, p_bit, p_lstb, p_bstb;
    logic [LAW_BITS-1:0]  p_byte;
    logic                 samp_done;
    logic [SAMP_BITS-1:0] sample;
    logic [WORD_BITS-1:0] lin_word;
    logic                 is_home;
    logic                 home_now;
    logic                 frame_end;
    logic [WORD_BITS-1:0] sig_next;
    logic [WORD_BITS-1:0] emit_word;
    logic [WORD_BITS-1:0] cod_step;

    efst_fifo_if #(.WIDTH(FIFO_WIDTH)) fin ();
    efst_fifo_if #(.WIDTH(FIFO_WIDTH)) fout ();

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_comb begin
        sync1_d = {i_law_mode, i_law_alaw, i_lin_bit, i_lin_strobe, i_law_strobe, i_law_byte};
        sync2_d = sync1_q;
        {p_mode, p_alaw, p_bit, p_lstb, p_bstb, p_byte} = sync2_q;
        lstb_d  = p_lstb;
        bstb_d  = p_bstb;
    end

    // ------------------------------------------------------------
    // Sample assembly
    // ------------------------------------------------------------
    always_comb begin
        samp_done = 1'b0;
        sample    = '0;
        shreg_d   = shreg_q;
        bcnt_d    = bcnt_q;
        if (p_mode) begin
            bcnt_d = '0;
            if (p_bstb && !bstb_q) begin
                samp_done = 1'b1;
                sample    = efst_law_expand(p_byte, p_alaw);
            end
        end else if (p_lstb && !lstb_q) begin
            shreg_d = {shreg_q[SAMP_BITS-3:0], p_bit};
            if (bcnt_q == LAST_BIT) begin
                samp_done = 1'b1;
                sample    = {shreg_q, p_bit};
                bcnt_d    = '0;
            end else begin
                bcnt_d = bcnt_q + BCNT_W'(1);
            end
        end
        lin_word = {sample, 3'b000};
        is_home  = (lin_word == HOME_WORD);
    end

    // ------------------------------------------------------------
    // Framing, homing and coding
    // ------------------------------------------------------------
    always_comb begin
        scnt_d      = scnt_q;
        all_home_d  = all_home_q;
        prev_home_d = prev_home_q;
        sig_d       = sig_q;
        cod_sig_d   = cod_sig_q;
        dhf_sel_d   = dhf_sel_q;
        cidx_d      = cidx_q;
        st_d        = st_q;
        home_seen_d = 1'b0;
        overrun_d   = overrun_q;
        sig_next    = efst_sig_step(sig_q, sample);
        home_now    = ((scnt_q == '0) | all_home_q) & is_home;
        frame_end   = samp_done && (scnt_q == LAST_SAMP);
        emit_word   = '0;
        cod_step    = efst_sig_step(cod_sig_q, SAMP_BITS'(cidx_q));
        fin.valid   = 1'b0;
        fin.data    = '0;

        if (samp_done) begin
            all_home_d = home_now;
            sig_d      = sig_next;
            scnt_d     = scnt_q + SCNT_W'(1);
        end
        if (frame_end) begin
            scnt_d      = '0;
            prev_home_d = home_now;
            home_seen_d = home_now;
            if (home_now) begin
                sig_d = SIG_SEED;
            end
            if (st_q == EFST_EMIT) begin
                overrun_d = 1'b1;
            end else begin
                st_d      = EFST_EMIT;
                cidx_d    = '0;
                cod_sig_d = sig_next;
                dhf_sel_d = home_now & prev_home_q;
            end
        end

        case (st_q)
            EFST_IDLE: begin
                emit_word = '0;
            end
            EFST_EMIT: begin
                if (dhf_sel_q) begin
                    emit_word = {{(WORD_BITS-PARAM_BITS){1'b0}}, DHF_BASE ^ PARAM_BITS'(cidx_q)};
                end else begin
                    emit_word = {{(WORD_BITS-PARAM_BITS){1'b0}}, cod_step[PARAM_BITS-1:0]};
                end
                fin.valid = 1'b1;
                fin.data  = {(cidx_q == '0), emit_word};
                if (fin.ready) begin
                    cidx_d = cidx_q + CCNT_W'(1);
                    if (cidx_q == LAST_WORD) begin
                        st_d = EFST_IDLE;
                    end
                end
            end
            default: begin
                st_d = EFST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            sync1_q     <= '0;
            sync2_q     <= '0;
            lstb_q      <= 1'b0;
            bstb_q      <= 1'b0;
            shreg_q     <= '0;
            bcnt_q      <= '0;
            scnt_q      <= '0;
            all_home_q  <= 1'b0;
            prev_home_q <= 1'b0;
            sig_q       <= SIG_SEED;
            cod_sig_q   <= '0;
            dhf_sel_q   <= 1'b0;
            cidx_q      <= '0;
            st_q        <= EFST_IDLE;
            home_seen_q <= 1'b0;
            overrun_q   <= 1'b0;
        end else if (i_ce) begin
            sync1_q     <= sync1_d;
            sync2_q     <= sync2_d;
            lstb_q      <= lstb_d;
            bstb_q      <= bstb_d;
            shreg_q     <= shreg_d;
            bcnt_q      <= bcnt_d;
            scnt_q      <= scnt_d;
            all_home_q  <= all_home_d;
            prev_home_q <= prev_home_d;
            sig_q       <= sig_d;
            cod_sig_q   <= cod_sig_d;
            dhf_sel_q   <= dhf_sel_d;
            cidx_q      <= cidx_d;
            st_q        <= st_d;
            home_seen_q <= home_seen_d;
            overrun_q   <= overrun_d;
        end
    end

    // ------------------------------------------------------------
    // Output FIFO
    // ------------------------------------------------------------
    efst_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_ce    (i_ce),
        .wr      (fin.snk),
        .rd      (fout.src)
    );

    assign fout.ready  = i_cod_ready & i_ce;
    assign o_cod_valid = fout.valid;
    assign o_cod_first = fout.data[WORD_BITS];
    assign o_cod_word  = fout.data[WORD_BITS-1:0];
    assign o_home_seen = home_seen_q;
    assign o_overrun   = overrun_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_home_word_value: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_ce && samp_done && sample == SAMP_BITS'(1)) |-> is_home)
        else $error("Sample of value one not taken as homing word");

    chk_dhf_on_second: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_ce && frame_end && home_now && prev_home_q && st_q == EFST_IDLE)
        |=> (st_q == EFST_EMIT && dhf_sel_q && cidx_q == '0))
        else $error("Second homing frame did not start decoder homing output");

    chk_home_state_reset: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_ce && frame_end && home_now) |=> (sig_q == SIG_SEED && scnt_q == '0))
        else $error("Homing frame did not restore home state");

    chk_sig_carried: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_ce && frame_end && !home_now && st_q == EFST_IDLE) |=> (cod_sig_q == $past(sig_next) && !dhf_sel_q))
        else $error("Coded frame not tied to frame content");

    chk_left_justify: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        samp_done |-> (lin_word[2:0] == 3'b000 && lin_word[WORD_BITS-1:3] == sample))
        else $error("Linear word not left justified");

    chk_right_justify: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        o_cod_valid |-> (o_cod_word[WORD_BITS-1:PARAM_BITS] == '0))
        else $error("Coded word not right justified");

    chk_law_byte_sample: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_ce && p_mode && p_bstb && !bstb_q) |-> (samp_done && bcnt_d == '0))
        else $error("Compressed byte did not yield one sample");

    chk_bit_count_wrap: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_ce && samp_done && !p_mode) |-> ($past(bcnt_q) <= LAST_BIT && bcnt_q == LAST_BIT ##1 bcnt_q == '0))
        else $error("Linear sample not closed after 13 bits");

endmodule // efst_core

/* efst_seq_model.sv */
// Sequencer side model: feeds linear bits or compressed bytes, consumes coded words.
// Assumes the core samples its pins through synchronisers on the rising edge.
`timescale 1ns/100ps

module efst_seq_model
    import efst_pkg::*;
(
    input  wire logic           i_clock,
    output logic                o_lin_bit,
    output logic                o_lin_strobe,
    output logic [LAW_BITS-1:0] o_law_byte,
    output logic                o_law_strobe,
    output logic                o_cod_ready
);
    localparam logic [LAW_BITS-1:0] HOME_LAW = 8'hd5; // A-law code expanding to one
    int stall_mode = 0; // 0 run, 1 every other cycle, 2 stopped

    initial begin
        o_lin_bit    = 1'b0;
        o_lin_strobe = 1'b0;
        o_law_byte   = 8'h00;
        o_law_strobe = 1'b0;
        o_cod_ready  = 1'b1;
    end

    // ------------------------------------------------------------
    // Consumer and input drivers
    // ------------------------------------------------------------
    always @(negedge i_clock) begin
        o_cod_ready <= (stall_mode == 0) || ((stall_mode == 1) && !o_cod_ready);
    end

    // One bit, 2 clocks high and 2 low; the line turns over once the strobe falls
    task automatic send_bit(input logic b);
        @(negedge i_clock);
        o_lin_bit    = b;
        o_lin_strobe = 1'b1;
        repeat (2) @(negedge i_clock);
        o_lin_strobe = 1'b0;
        o_lin_bit    = ~b;
        @(negedge i_clock);
    endtask

    // Homing trial: leading slip bits, then n homing frames, MSB first
    task automatic lin_home(input int pre_bits, input int n);
        repeat (pre_bits) send_bit(1'b0);
        for (int i = 0; i < n * FRAME_SAMPLES; i++) begin
            for (int b = SAMP_BITS - 1; b >= 0; b--) begin
                send_bit(HOME_WORD[b + 3]);
            end
        end
    endtask

    // Byte stable 3 clocks around the strobe rise, then released
    task automatic send_byte(input logic [LAW_BITS-1:0] v);
        @(negedge i_clock);
        o_law_byte = v;
        repeat (3) @(negedge i_clock);
        o_law_strobe = 1'b1;
        repeat (3) @(negedge i_clock);
        o_law_strobe = 1'b0;
        o_law_byte   = ~v;
    endtask

    // Frame of lead homing slots, then base xor position
    task automatic law_frame(input logic [LAW_BITS-1:0] base, input int lead);
        for (int i = 0; i < FRAME_SAMPLES; i++) begin
            send_byte((i < lead) ? HOME_LAW : (base ^ LAW_BITS'(i - lead)));
        end
    endtask
endmodule // efst_seq_model

/* tb_top.sv */
// Self-checking bench for the encoder framing core.
// Assumes efst_pkg and the sequencer model are compiled first.
`timescale 1ns/100ps

module tb_top;
    import efst_pkg::*;
    logic                 clock = 1'b0;
    logic                 rst_b = 1'b0;
    logic                 ce = 1'b1;
    logic                 law_mode = 1'b1;
    logic                 law_alaw = 1'b1;
    logic                 lin_bit, lin_strobe, law_strobe, cod_ready;
    logic [LAW_BITS-1:0]  law_byte;
    logic [WORD_BITS-1:0] cod_word;
    logic                 cod_first, cod_valid, home_seen, overrun;
    logic [WORD_BITS-1:0] cap [COD_WORDS];
    int                   cap_n = 0, frames_got = 0, homes = 0;
    int                   fails = 0, samples_checked = 0;

    initial begin
        forever #4 clock = ~clock;
    end

    efst_core efst_core_inst (.i_clock(clock), .i_rst_b(rst_b), .i_ce(ce), .i_law_mode(law_mode),
        .i_law_alaw(law_alaw), .i_lin_bit(lin_bit), .i_lin_strobe(lin_strobe), .i_law_byte(law_byte),
        .i_law_strobe(law_strobe), .i_cod_ready(cod_ready), .o_cod_word(cod_word),
        .o_cod_first(cod_first), .o_cod_valid(cod_valid), .o_home_seen(home_seen), .o_overrun(overrun));
    efst_seq_model efst_seq_model_inst (.i_clock(clock), .o_lin_bit(lin_bit), .o_lin_strobe(lin_strobe),
        .o_law_byte(law_byte), .o_law_strobe(law_strobe), .o_cod_ready(cod_ready));

    // ------------------------------------------------------------
    // Compare and capture
    // ------------------------------------------------------------
    task automatic chk_word(input logic [WORD_BITS-1:0] got, input logic [WORD_BITS-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    always @(posedge clock) begin
        if (rst_b && ce && cod_valid && cod_ready) begin
            if (cod_first) begin
                chk_word(16'(cap_n), 16'(COD_WORDS));
                cap_n = 0;
                frames_got++;
            end
            if (cap_n < COD_WORDS) begin
                cap[cap_n] = cod_word;
            end
            cap_n++;
            chk_word(cod_word & 16'hffc0, 16'h0000);
        end
        if (rst_b && home_seen) begin
            homes++;
        end
    end

    task automatic wait_frame(input int target);
        int n;
        n = 0;
        while (!(frames_got >= target && cap_n == COD_WORDS) && n < 4000) begin
            @(negedge clock);
            n++;
        end
        chk_flag(n < 4000, 1'b1);
    endtask

    task automatic chk_dhf();
        for (int k = 0; k < COD_WORDS; k++) begin
            chk_word(cap[k], {10'h000, DHF_BASE ^ PARAM_BITS'(k % 64)});
        end
    endtask

    task automatic do_reset();
        @(negedge clock);
        rst_b = 1'b0;
        cap_n = COD_WORDS;
        repeat (8) @(negedge clock);
        rst_b = 1'b1;
        chk_flag(cod_valid | cod_first | home_seen | overrun, 1'b0);
        chk_word(cod_word, 16'h0000);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_law_home();
        int f0, h0;
        f0 = frames_got;
        h0 = homes;
        repeat (2) efst_seq_model_inst.law_frame(8'h00, FRAME_SAMPLES);
        wait_frame(f0 + 2);
        chk_word(16'(homes - h0), 16'h0002);
        chk_dhf();
        $display("law homing done");
    endtask

    task automatic sync_run(input int lag, input int slow);
        int f0;
        f0 = frames_got;
        efst_seq_model_inst.stall_mode = slow;
        repeat (3) efst_seq_model_inst.law_frame(8'h00, FRAME_SAMPLES);
        efst_seq_model_inst.law_frame(8'h3c, lag);
        wait_frame(f0 + 4);
        efst_seq_model_inst.stall_mode = 0;
    endtask

    task automatic t_sync();
        logic [WORD_BITS-1:0] ref0 [COD_WORDS];
        logic                 same;
        int                   lags [2] = '{1, 159};
        sync_run(0, 0);
        ref0 = cap;
        sync_run(0, 1);
        for (int k = 0; k < COD_WORDS; k++) begin
            chk_word(cap[k], ref0[k]);
        end
        foreach (lags[i]) begin
            sync_run(lags[i], 0);
            same = 1'b1;
            for (int k = 0; k < COD_WORDS; k++) begin
                same &= (cap[k] === ref0[k]);
            end
            chk_flag(same, 1'b0);
        end
        sync_run(0, 0);
        for (int k = 0; k < COD_WORDS; k++) begin
            chk_word(cap[k], ref0[k]);
        end
        $display("sync offsets done");
    endtask

    task automatic t_mulaw();
        int f0, h0;
        law_alaw = 1'b0;
        f0 = frames_got;
        h0 = homes;
        efst_seq_model_inst.law_frame(8'h00, FRAME_SAMPLES);
        wait_frame(f0 + 1);
        chk_word(16'(homes - h0), 16'h0000);
        law_alaw = 1'b1;
        $display("mu-law done");
    endtask

    task automatic t_overrun();
        logic [WORD_BITS-1:0] w;
        int                   n;
        efst_seq_model_inst.stall_mode = 2;
        efst_seq_model_inst.law_frame(8'h11, 0);
        efst_seq_model_inst.law_frame(8'h22, 0);
        n = 0;
        while (overrun !== 1'b1 && n < 100) begin
            @(negedge clock);
            n++;
        end
        chk_flag(overrun, 1'b1);
        chk_flag(cod_valid, 1'b1);
        ce = 1'b0;
        efst_seq_model_inst.stall_mode = 0;
        w = cod_word;
        repeat (4) @(negedge clock);
        chk_word(cod_word, w);
        ce = 1'b1;
        do_reset();
        $display("overrun done");
    endtask

    task automatic t_lin();
        int f0, h0;
        law_mode = 1'b0;
        do_reset();
        h0 = homes;
        efst_seq_model_inst.lin_home(1, 2);
        chk_word(16'(homes - h0), 16'h0000);
        do_reset();
        f0 = frames_got;
        h0 = homes;
        efst_seq_model_inst.lin_home(0, 2);
        wait_frame(f0 + 2);
        chk_word(16'(homes - h0), 16'h0002);
        chk_dhf();
        $display("linear bit trials done");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clock);
        fails++;
        summarize();
    end

    initial begin
        do_reset();
        t_law_home();
        t_sync();
        t_mulaw();
        t_overrun();
        t_lin();
        summarize();
    end
endmodule // tb_top
